// File: design/sad_decoder.sv
// system address decoder with region attributes and fuse port
// assumes requests come from same-clock bus logic, one per cycle
module sad_decoder
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire sad_pkg::sad_req_type req_i,
    output sad_pkg::sad_resp_type resp_o,
    input wire logic ulp_mode_i,
    input wire logic lifecycle_secure_i,
    input wire logic [2:0] sysfn_req_i,
    output logic nmi_secondary_o,
    input wire logic cfg_we_i,
    input wire logic [2:0] cfg_ctx_i,
    input wire logic [5:0] cfg_idx_i,
    input wire logic [2:0] cfg_rights_i,
    input wire logic fuse_prog_i,
    input wire logic [2:0] fuse_ctx_i,
    input wire logic [4:0] fuse_word_i,
    input wire logic [31:0] fuse_mask_i,
    input wire logic [4:0] fuse_rd_word_i,
    output logic [31:0] fuse_rdata_o,
    input wire logic retain_all_i,
    input wire logic [8:0] retain_blocks_i,
    output logic [8:0] sram_retain_o
);
    import sad_pkg::*;

    // ==========================================================
    // region decode
    // map an address to its target, none where nothing backs it
    function automatic sad_target_type decode(input logic [31:0] a);
        if (a <= CODE_LAST)
        begin
            // code region holds rom, sram, flash and xip
            if (a <= ROM_LAST)
                decode = TGT_ROM;
            else if (a >= SRAM_BASE && a <= SRAM_LAST)
                decode = TGT_SRAM;
            else if (a >= APPF_BASE && a <= APPF_LAST)
                decode = TGT_APPF;
            else if (a >= AUXF_BASE && a <= AUXF_LAST)
                decode = TGT_AUXF;
            else if (a >= SUPF_BASE && a <= SUPF_LAST)
                decode = TGT_SUPF;
            else if (a >= XIP_BASE)
                decode = TGT_XIP;
            else
                decode = TGT_NONE;
        end
        else if (a >= PERI_BASE && a <= PERI_LAST)
            decode = TGT_PERI;
        else if (a >= SMEM_BASE && a <= SMEM_LAST)
            decode = TGT_SMEM;
        else if (a >= PPB_BASE && a <= PPB_LAST)
            decode = TGT_PPB;
        else if (a >= DEV_BASE)
            decode = TGT_DEV;
        else
            decode = TGT_NONE; // 2000_0000 region and the gap above serial memory are empty
    endfunction : decode

    // true for any of the three flash sectors
    function automatic logic is_flash(input sad_target_type t);
        is_flash = (t == TGT_APPF) || (t == TGT_AUXF) || (t == TGT_SUPF);
    endfunction : is_flash

    // regions that may hold code
    function automatic logic is_exec(input sad_target_type t);
        is_exec = (t == TGT_ROM) || (t == TGT_SRAM) || is_flash(t)
                  || (t == TGT_XIP) || (t == TGT_SMEM);
    endfunction : is_exec

    // ==========================================================
    // state
    typedef struct packed {
        sad_resp_type resp;   // registered answer
        logic nmi;            // system-call nmi pulse
        logic [8:0] retain;   // sram retention enables
    } sad_dec_state_type;
    sad_dec_state_type st, next_st;

    // ==========================================================
    // protection unit
    logic prot_allow; // rights table verdict
    sad_prot_unit u_prot
    (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .cfg_we_i(cfg_we_i),
        .cfg_ctx_i(cfg_ctx_i),
        .cfg_idx_i(cfg_idx_i),
        .cfg_rights_i(cfg_rights_i),
        .req_i(req_i),
        .allow_o(prot_allow)
    );

    // ==========================================================
    // fuse array
    logic fuse_ok; // programming permitted for this word
    // system half only from boot context; customer half open
    assign fuse_ok = fuse_prog_i
                     && (fuse_word_i >= 5'(FUSE_SYS_WORDS) || fuse_ctx_i == BOOT_CTX);
    sad_fuse_mem u_fuse
    (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .prog_i(fuse_ok),
        .word_i(fuse_word_i),
        .mask_i(fuse_mask_i),
        .rd_word_i(fuse_rd_word_i),
        .rdata_o(fuse_rdata_o)
    );

    // ==========================================================
    // access checks
    sad_target_type tgt;  // decoded target
    logic err;            // bus error verdict
    logic flash_wr;       // legal flash row write
    always_comb
    begin
        tgt = decode(req_i.addr);
        err = 1'b0;
        // nothing behind the address
        if (tgt == TGT_NONE)
            err = 1'b1;
        // fetch from a data-only region
        if (req_i.fetch && !is_exec(tgt))
            err = 1'b1;
        // rom only for the secondary cpu in boot context
        if (tgt == TGT_ROM
            && (req_i.master != MST_SECONDARY_CPU || req_i.ctx != BOOT_CTX
                || req_i.write))
            err = 1'b1;
        // supervisory regions closed to non-secure accesses
        if ((tgt == TGT_ROM || tgt == TGT_SUPF) && !req_i.secure)
            err = 1'b1;
        // rights table check
        if (!prot_allow)
            err = 1'b1;
        // flash write restrictions
        if (is_flash(tgt) && req_i.write && ulp_mode_i)
            err = 1'b1;
        if (tgt == TGT_SUPF && req_i.write && lifecycle_secure_i)
            err = 1'b1;
        flash_wr = is_flash(tgt) && req_i.write && !err;
    end

    // ==========================================================
    // next state
    always_comb
    begin
        next_st = st;
        next_st.resp.valid = req_i.valid;
        next_st.resp.err = req_i.valid && err;
        next_st.resp.target = req_i.valid ? tgt : TGT_NONE;
        // 128-bit word index of the flash access
        next_st.resp.flash_word = req_i.addr[31:FLASH_WORD_LSB];
        // 512-byte row for programming
        next_st.resp.flash_row = req_i.addr[31:FLASH_ROW_LSB];
        next_st.resp.row_write = req_i.valid && flash_wr;
        // flash reads go through the issuing cpu's cache
        next_st.resp.cache_sel = 2'h0;
        if (req_i.valid && is_flash(tgt) && !req_i.write && !err)
        begin
            if (req_i.master == MST_MAIN_CPU)
                next_st.resp.cache_sel = 2'h1;
            else if (req_i.master == MST_SECONDARY_CPU)
                next_st.resp.cache_sel = 2'h2;
        end
        // any system-call request raises the nmi
        next_st.nmi = |sysfn_req_i;
        // retention whole array or chosen blocks
        next_st.retain = retain_all_i ? RETAIN_RESET : retain_blocks_i;
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            st <= '0;
            st.resp.target <= TGT_NONE;
            st.retain <= RETAIN_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign resp_o = st.resp;
    assign nmi_secondary_o = st.nmi;
    assign sram_retain_o = st.retain;

    // ==========================================================
    // checks
    AST_PERI_FETCH: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.fetch && req_i.addr >= PERI_BASE && req_i.addr <= PERI_LAST)
        |=> (resp_o.valid && resp_o.err && resp_o.target == TGT_PERI))
        else $error("fetch from peripheral region not refused");

    AST_SRAM_HOLE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.addr[31:29] == 3'h1) |=> (resp_o.err && resp_o.target == TGT_NONE))
        else $error("empty sram region did not error");

    AST_ROM_OWNER: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.addr <= ROM_LAST && req_i.master != MST_SECONDARY_CPU)
        |=> resp_o.err)
        else $error("rom reached by wrong master");

    AST_ULP_WRITE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.write && ulp_mode_i && req_i.addr >= APPF_BASE
         && req_i.addr <= APPF_LAST) |=> (resp_o.err && !resp_o.row_write))
        else $error("flash write allowed in ultra-low-power mode");

    AST_SUPF_LOCK: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.write && lifecycle_secure_i && req_i.addr >= SUPF_BASE
         && req_i.addr <= SUPF_LAST) |=> (resp_o.err && !resp_o.row_write))
        else $error("locked supervisory flash modified");

    AST_NMI: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (|sysfn_req_i) |=> nmi_secondary_o ##1 ($past(sysfn_req_i, 1) != 3'h0 || !nmi_secondary_o))
        else $error("system call did not raise nmi");

    AST_SMEM_FETCH: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.fetch && prot_allow && req_i.addr >= SMEM_BASE
         && req_i.addr <= SMEM_LAST) |=> (!resp_o.err && resp_o.target == TGT_SMEM))
        else $error("fetch from serial memory refused");

    AST_ROW: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        resp_o.row_write |-> (resp_o.flash_row == resp_o.flash_word[27:5] && !resp_o.err))
        else $error("row index does not match word index");

    AST_RETAIN: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        retain_all_i [*2] |-> sram_retain_o == RETAIN_RESET)
        else $error("whole-array retention not applied");

    AST_PPB: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (req_i.valid && req_i.addr >= PPB_BASE && req_i.addr <= PPB_LAST)
        |=> resp_o.target == TGT_PPB)
        else $error("private bus address misrouted");
endmodule : sad_decoder

// File: design/sad_fuse_mem.sv
// one-time fuse array: bits only ever go from 0 to 1
// assumes the caller has already vetted who may program
module sad_fuse_mem
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic prog_i,
    input wire logic [4:0] word_i,
    input wire logic [31:0] mask_i,
    input wire logic [4:0] rd_word_i,
    output logic [31:0] rdata_o
);
    import sad_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        logic [FUSE_WORDS-1:0][31:0] bits; // fuse cells
        logic [31:0] rdata;                // registered read data
    } sad_fuse_state_type;
    sad_fuse_state_type st, next_st;

    // program by or-ing, never clearing
    always_comb
    begin
        next_st = st;
        if (prog_i)
        begin
            next_st.bits[word_i] = st.bits[word_i] | mask_i;
        end
        next_st.rdata = st.bits[rd_word_i];
    end

    // cells model a blank array at reset
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            st <= '0;
        else
            st <= next_st;
    end
    assign rdata_o = st.rdata;

    AST_FUSE_NO_CLEAR: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (($past(st.bits) & ~st.bits) == '0))
        else $error("fuse bit went from one to zero");
endmodule : sad_fuse_mem

// File: design/sad_prot_unit.sv
// protection rights table, per context, master and privilege
// assumes configuration writes come only from boot code
module sad_prot_unit
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic cfg_we_i,
    input wire logic [2:0] cfg_ctx_i,
    input wire logic [5:0] cfg_idx_i,
    input wire logic [2:0] cfg_rights_i,
    input wire sad_pkg::sad_req_type req_i,
    output logic allow_o
);
    import sad_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        logic [63:0][2:0] rights; // {exec, write, read}
    } sad_prot_state_type;
    sad_prot_state_type st, next_st;

    // table index from context, master, privilege
    function automatic logic [5:0] idx(input logic [2:0] c, input logic [1:0] m,
                                       input logic p);
        idx = {c, m, p};
    endfunction : idx

    logic [2:0] r; // rights of the current access
    // load rights only from the boot context
    always_comb
    begin
        next_st = st;
        if (cfg_we_i && cfg_ctx_i == BOOT_CTX)
            next_st.rights[cfg_idx_i] = cfg_rights_i;
        r = st.rights[idx(req_i.ctx, req_i.master, req_i.priv)];
        // code/data and read/write attribute check
        if (req_i.fetch)
            allow_o = r[2];
        else if (req_i.write)
            allow_o = r[1];
        else
            allow_o = r[0];
    end

    // everything open until boot narrows it
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            st <= {64{RIGHTS_RESET}};
        else
            st <= next_st;
    end
endmodule : sad_prot_unit

// File: inc/sad_pkg.sv
// shared constants and carrier types for the system address decoder
// assumes one system clock and a synchronous active-high reset
package sad_pkg;
    // ==========================================================
    // region boundaries
    localparam logic [31:0] CODE_LAST = 32'h1fff_ffff;
    localparam logic [31:0] ROM_LAST = 32'h0001_ffff;
    localparam logic [31:0] SRAM_BASE = 32'h0800_0000;
    localparam logic [31:0] SRAM_LAST = 32'h0804_7fff;
    localparam logic [31:0] APPF_BASE = 32'h1000_0000;
    localparam logic [31:0] APPF_LAST = 32'h100f_ffff;
    localparam logic [31:0] AUXF_BASE = 32'h1400_0000;
    localparam logic [31:0] AUXF_LAST = 32'h1400_7fff;
    localparam logic [31:0] SUPF_BASE = 32'h1600_0000;
    localparam logic [31:0] SUPF_LAST = 32'h1600_7fff;
    localparam logic [31:0] XIP_BASE = 32'h1800_0000;
    localparam logic [31:0] PERI_BASE = 32'h4000_0000;
    localparam logic [31:0] PERI_LAST = 32'h5fff_ffff;
    localparam logic [31:0] SMEM_BASE = 32'h6000_0000;
    localparam logic [31:0] SMEM_LAST = 32'h9fff_ffff;
    localparam logic [31:0] PPB_BASE = 32'he000_0000;
    localparam logic [31:0] PPB_LAST = 32'he00f_ffff;
    localparam logic [31:0] DEV_BASE = 32'he010_0000;
    // ==========================================================
    // geometry
    localparam int FLASH_WORD_LSB = 4;      // 128-bit flash words
    localparam int FLASH_ROW_LSB = 9;       // 512-byte rows
    localparam int SECTOR_LSB = 18;         // 256 KB sectors
    localparam int CACHE_KB = 8;            // per-cpu flash cache
    localparam int CACHE_WAYS = 4;
    localparam int SRAM_BLOCKS = 9;         // 288 KB in 32 KB blocks
    localparam int FUSE_WORDS = 32;         // 1024 fuse bits
    localparam int FUSE_SYS_WORDS = 16;     // first 512 bits for system
    localparam int NUM_CTX = 8;
    localparam int NUM_MASTERS = 4;
    localparam logic [2:0] BOOT_CTX = 3'h0;
    localparam logic [2:0] RIGHTS_RESET = 3'h7; // read, write, execute
    localparam logic [8:0] RETAIN_RESET = 9'h1ff;
    // ==========================================================
    // masters and targets
    localparam logic [1:0] MST_MAIN_CPU = 2'h0;
    localparam logic [1:0] MST_SECONDARY_CPU = 2'h1;
    localparam logic [1:0] MST_DMA = 2'h2;
    localparam logic [1:0] MST_DEBUG_PORT = 2'h3;
    typedef enum logic [3:0] {
        TGT_NONE, TGT_ROM, TGT_SRAM, TGT_APPF, TGT_AUXF, TGT_SUPF,
        TGT_XIP, TGT_PERI, TGT_SMEM, TGT_PPB, TGT_DEV
    } sad_target_type;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic fetch;
        logic priv;
        logic secure;
        logic [2:0] ctx;
        logic [1:0] master;
    } sad_req_type;
    typedef struct packed {
        logic valid;
        logic err;
        sad_target_type target;
        logic [27:0] flash_word;
        logic [22:0] flash_row;
        logic row_write;
        logic [1:0] cache_sel;
    } sad_resp_type;
endpackage : sad_pkg

// File: verif/sad_master_model.sv
// bus master model: stands for the cpus, dma and debug port on the request bus
// assumes the decoder takes a request at one edge and answers after it
module sad_master_model
import sad_pkg::*;
(
    input wire logic sys_clk_i,
    output sad_pkg::sad_req_type req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // request driver
    initial req_o = '0;
    // one request held for exactly one taking edge, then released
    task automatic issue(input logic [31:0] a, input logic [3:0] f, input logic [2:0] c,
        input logic [1:0] m);
        @(posedge sys_clk_i);
        req_o <= '{valid: 1'b1, addr: a, write: f[3], fetch: f[2], priv: f[1],
                   secure: f[0], ctx: c, master: m};
        @(posedge sys_clk_i);
        req_o.valid <= 1'b0; // released after the taking edge
        req_o.addr <= ~a; // stale address is not kept on the bus
        #1;
    endtask : issue
endmodule : sad_master_model

// File: verif/system_address_decoder_test.sv
// self-checking bench for the system address decoder
// assumes one 50 MHz clock and a synchronous active-high reset
module system_address_decoder_test;
    import sad_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic sys_clk_i;
    logic srst_i;
    sad_req_type req;
    sad_resp_type resp;
    logic ultra_low_power_mode = 1'b0, lcs = 1'b0, nmi, cfg_we = 1'b0, fprog = 1'b0, rall = 1'b0;
    logic [2:0] sysfn = '0, cfg_ctx = '0, cfg_rights = '0, fctx = '0;
    logic [5:0] cfg_idx = '0;
    logic [4:0] fword = '0, frd = '0;
    logic [31:0] fmask = '0, frdata;
    logic [8:0] rblk = '0, retain;
    int fails = 0;
    int compares = 0;
    localparam logic [3:0] RD = 4'b0011; // privileged secure read
    localparam logic [3:0] WR = 4'b1011; // privileged secure write
    localparam logic [3:0] FE = 4'b0111; // privileged secure fetch
    // ==========================================================
    // clock and instances
    initial
    begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    sad_master_model mdl (.sys_clk_i(sys_clk_i), .req_o(req));
    sad_decoder dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req), .resp_o(resp),
        .ulp_mode_i(ultra_low_power_mode), .lifecycle_secure_i(lcs), .sysfn_req_i(sysfn),
        .nmi_secondary_o(nmi), .cfg_we_i(cfg_we), .cfg_ctx_i(cfg_ctx), .cfg_idx_i(cfg_idx),
        .cfg_rights_i(cfg_rights), .fuse_prog_i(fprog), .fuse_ctx_i(fctx),
        .fuse_word_i(fword), .fuse_mask_i(fmask), .fuse_rd_word_i(frd),
        .fuse_rdata_o(frdata), .retain_all_i(rall), .retain_blocks_i(rblk),
        .sram_retain_o(retain));
    // ==========================================================
    // shared helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one access; target only judged when the access should succeed
    task automatic acc(input logic [31:0] a, input logic [3:0] f, input logic [2:0] c,
        input logic [1:0] m, input sad_target_type t, input logic e);
        mdl.issue(a, f, c, m);
        chk("valid", 32'(resp.valid), 32'h1);
        chk("err", 32'(resp.err), 32'(e));
        if (!e)
            chk("target", 32'(resp.target), 32'(t));
        else
            chk("row_write", 32'(resp.row_write), 32'h0);
    endtask : acc
    task automatic fuse(input logic [4:0] w, input logic [31:0] m, input logic [2:0] c,
        input logic [31:0] exp);
        @(posedge sys_clk_i);
        fprog <= 1'b1;
        fword <= w;
        fmask <= m;
        fctx <= c;
        @(posedge sys_clk_i);
        fprog <= 1'b0;
        frd <= w;
        @(posedge sys_clk_i);
        #1 chk("fuse_rdata", frdata, exp);
    endtask : fuse
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // scenarios
    task automatic t_regions;
        logic [31:0] a [20] = '{32'h0, 32'h0001_ffff, 32'h0002_0000, 32'h0800_0000,
            32'h0804_7fff, 32'h0804_8000, 32'h1000_0000, 32'h100f_ffff, 32'h1400_7fff,
            32'h1600_0000, 32'h1800_0000, 32'h1fff_ffff, 32'h2000_0000, 32'h4000_0000,
            32'h6000_0000, 32'h9fff_ffff, 32'ha000_0000, 32'he000_0000, 32'he00f_ffff,
            32'he010_0000};
        sad_target_type t [20] = '{TGT_ROM, TGT_ROM, TGT_NONE, TGT_SRAM, TGT_SRAM,
            TGT_NONE, TGT_APPF, TGT_APPF, TGT_AUXF, TGT_SUPF, TGT_XIP, TGT_XIP, TGT_NONE,
            TGT_PERI, TGT_SMEM, TGT_SMEM, TGT_NONE, TGT_PPB, TGT_PPB, TGT_DEV};
        for (int i = 0; i < 20; i++)
            acc(a[i], RD, 3'h0, MST_SECONDARY_CPU, t[i], t[i] == TGT_NONE);
    endtask : t_regions
    task automatic t_attr;
        acc(32'h1000_0210, RD, 3'h0, MST_MAIN_CPU, TGT_APPF, 1'b0);
        chk("flash_word", 32'(resp.flash_word), 32'h0100_0021);
        chk("flash_row", 32'(resp.flash_row), 32'h0008_0001);
        chk("cache_sel", 32'(resp.cache_sel), 32'h1);
        acc(32'h1000_0210, RD, 3'h0, MST_SECONDARY_CPU, TGT_APPF, 1'b0);
        chk("cache_sel", 32'(resp.cache_sel), 32'h2);
        acc(32'h4000_0100, FE, 3'h0, MST_MAIN_CPU, TGT_PERI, 1'b1);
        acc(32'h6000_0100, FE, 3'h0, MST_MAIN_CPU, TGT_SMEM, 1'b0);
        acc(32'he000_0100, FE, 3'h0, MST_MAIN_CPU, TGT_PPB, 1'b1);
        acc(32'h1800_0100, FE, 3'h0, MST_MAIN_CPU, TGT_XIP, 1'b0);
        acc(32'h0000_0100, RD, 3'h0, MST_MAIN_CPU, TGT_ROM, 1'b1);
        acc(32'h0000_0100, RD, 3'h1, MST_SECONDARY_CPU, TGT_ROM, 1'b1);
        acc(32'h1600_0000, 4'b0010, 3'h0, MST_MAIN_CPU, TGT_SUPF, 1'b1);
    endtask : t_attr
    task automatic t_flash;
        acc(32'h1000_0200, WR, 3'h0, MST_MAIN_CPU, TGT_APPF, 1'b0);
        chk("row_write", 32'(resp.row_write), 32'h1);
        ultra_low_power_mode <= 1'b1;
        acc(32'h1000_0200, WR, 3'h0, MST_MAIN_CPU, TGT_APPF, 1'b1);
        acc(32'h1000_0200, RD, 3'h0, MST_MAIN_CPU, TGT_APPF, 1'b0);
        ultra_low_power_mode <= 1'b0;
        lcs <= 1'b1;
        acc(32'h1600_0000, WR, 3'h0, MST_SECONDARY_CPU, TGT_SUPF, 1'b1);
        lcs <= 1'b0;
        acc(32'h1600_0000, WR, 3'h0, MST_SECONDARY_CPU, TGT_SUPF, 1'b0);
    endtask : t_flash
    task automatic t_rights;
        @(posedge sys_clk_i);
        cfg_we <= 1'b1;
        cfg_idx <= 6'h0c; // context 1, dma, unprivileged
        @(posedge sys_clk_i);
        cfg_ctx <= 3'h1; // refused: not written from context 0
        cfg_idx <= 6'h0e;
        @(posedge sys_clk_i);
        cfg_we <= 1'b0;
        acc(32'h0800_0000, 4'b0001, 3'h1, MST_DMA, TGT_SRAM, 1'b1);
        acc(32'h0800_0000, RD, 3'h1, MST_DMA, TGT_SRAM, 1'b0);
        acc(32'h0800_0000, 4'b0001, 3'h1, MST_DEBUG_PORT, TGT_SRAM, 1'b0);
    endtask : t_rights
    task automatic t_fuse;
        fuse(5'd20, 32'h1, 3'h3, 32'h1);
        fuse(5'd20, 32'h2, 3'h3, 32'h3);
        fuse(5'd3, 32'hff, 3'h1, 32'h0);
        fuse(5'd3, 32'hff, 3'h0, 32'hff);
    endtask : t_fuse
    task automatic t_nmi;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge sys_clk_i);
            sysfn <= 3'(1 << i);
            @(posedge sys_clk_i);
            sysfn <= 3'h0;
            #1 chk("nmi", 32'(nmi), 32'h1);
            @(posedge sys_clk_i);
            #1 chk("nmi", 32'(nmi), 32'h0);
        end
    endtask : t_nmi
    task automatic t_retain;
        @(posedge sys_clk_i);
        rblk <= 9'h005;
        @(posedge sys_clk_i);
        #1 chk("retain", 32'(retain), 32'h005);
        rall <= 1'b1;
        @(posedge sys_clk_i);
        #1 chk("retain", 32'(retain), 32'h1ff);
    endtask : t_retain
    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        srst_i = 1'b1;
        repeat (20) @(posedge sys_clk_i);
        #1 chk("retain_rst", 32'(retain), 32'h1ff);
        chk("resp_rst", 32'(resp.valid), 32'h0);
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        t_regions();
        t_attr();
        t_flash();
        t_rights();
        t_fuse();
        t_nmi();
        t_retain();
        wrap_up();
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        fails++;
        wrap_up();
    end
endmodule : system_address_decoder_test
